// ### verilog/timer2_uart_pkg.sv
// Shared constants and types for the timer 2 and serial port block.
package timer2_uart_pkg;
   localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
   localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
   localparam logic [7:0] TIMER2_CONTROL_ADDR = 8'hC8;
   localparam logic [7:0] RELOAD_CAPTURE_LOW_ADDR = 8'hCA;
   localparam logic [7:0] RELOAD_CAPTURE_HIGH_ADDR = 8'hCB;
   localparam logic [7:0] TIMER2_COUNT_LOW_ADDR = 8'hCC;
   localparam logic [7:0] TIMER2_COUNT_HIGH_ADDR = 8'hCD;

   localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
   localparam logic [7:0] SERIAL_DATA_BUFFER_RESET = 8'h00;
   localparam logic [7:0] TIMER2_CONTROL_RESET = 8'h00;
   localparam logic [15:0] RELOAD_CAPTURE_RESET = 16'h0000;
   localparam logic [15:0] TIMER2_COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Sixteen oversample ticks make one UART bit; the receiver samples mid-bit.
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] SAMPLE_PHASE = 4'h7;
   localparam logic [3:0] SHIFT_LAST_BIT = 4'h7;
   localparam logic [3:0] UART8_STOP_INDEX = 4'h9;
   localparam logic [3:0] UART9_STOP_INDEX = 4'hA;
   localparam logic [3:0] UART8_LAST_DATA = 4'h8;
   localparam logic [3:0] UART9_LAST_DATA = 4'h9;

   typedef enum logic [1:0] {SER_SHIFT, SER_UART8, SER_UART9_FIXED, SER_UART9_VAR} ser_mode_t;
   typedef enum logic [1:0] {T2_OFF, T2_AUTORELOAD, T2_CAPTURE, T2_BAUD} t2_mode_t;
   typedef enum logic [1:0] {TX_IDLE, TX_UART, TX_SHIFT} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_UART, RX_SHIFT} rx_state_t;

   typedef struct packed {
      logic timer2_overflow_flag;
      logic ext_trigger_flag;
      logic rx_clock_select;
      logic tx_clock_select;
      logic ext_trigger_enable;
      logic timer2_run;
      logic counter_select;
      logic capture_select;
   } timer2_control_t;

   typedef struct packed {
      ser_mode_t mode_select;
      logic multiproc_filter;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } serial_control_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage

// ### verilog/timer2_uart.sv
// Timer 2 (autoreload, capture, baud generator) with the receive-buffered serial port.
module timer2_uart
   import timer2_uart_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic baud_double,
   input wire logic timer1_overflow,
   input wire logic ext_trigger_pin,
   input wire logic timer2_count_input,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd,
   output logic timer2_irq,
   output logic serial_irq,
   output logic timer2_overflow_pulse
);

   function automatic logic wr_hit(input sfr_req_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // Pin synchronisers; the third stage only serves edge detection.
   logic [2:0] pin_async;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;
   assign pin_async = {rxd_in, timer2_count_input, ext_trigger_pin};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge core_clk) begin
         if (srst) begin
            sync1_r[i] <= 1'b1;
            sync2_r[i] <= 1'b1;
            sync3_r[i] <= 1'b1;
         end else begin
            sync1_r[i] <= pin_async[i];
            sync2_r[i] <= sync1_r[i];
            sync3_r[i] <= sync2_r[i];
         end
      end
   end

   logic ext_fall;
   logic count_pin_fall;
   logic rxd_s;
   logic rxd_fall;
   assign ext_fall = sync3_r[0] & ~sync2_r[0];
   assign count_pin_fall = sync3_r[1] & ~sync2_r[1];
   assign rxd_s = sync2_r[2];
   assign rxd_fall = sync3_r[2] & ~sync2_r[2];

   timer2_control_t timer2_control_r;
   serial_control_t serial_control_r;
   logic [15:0] rcap_r;
   logic [15:0] count_r;
   logic [7:0] rx_buf_r;
   logic [7:0] rdata_r;
   logic prescale_r;
   logic t1_half_r;
   logic t2_ovf_r;
   logic timer2_irq_r;
   logic serial_irq_r;

   t2_mode_t t2_mode;
   logic count_event;
   logic ovf;
   logic ext_event;
   logic reload;
   logic capture;

   always_comb begin
      if (!timer2_control_r.timer2_run) begin
         t2_mode = T2_OFF;
      end else if (timer2_control_r.rx_clock_select || timer2_control_r.tx_clock_select) begin
         t2_mode = T2_BAUD;
      end else if (timer2_control_r.capture_select) begin
         t2_mode = T2_CAPTURE;
      end else begin
         t2_mode = T2_AUTORELOAD;
      end
   end

   // In baud mode with counter_select clear the timer ticks every other clock, as the serial divider expects.
   always_comb begin
      if (t2_mode == T2_OFF) begin
         count_event = 1'b0;
      end else if (timer2_control_r.counter_select) begin
         count_event = count_pin_fall;
      end else begin
         count_event = (t2_mode == T2_BAUD) ? prescale_r : 1'b1;
      end
   end

   assign ovf = count_event && (count_r == COUNT_ALL_ONES);
   assign ext_event = ext_fall && timer2_control_r.ext_trigger_enable && (t2_mode != T2_OFF);
   assign reload = (ovf && (t2_mode == T2_AUTORELOAD || t2_mode == T2_BAUD))
      || (ext_event && t2_mode == T2_AUTORELOAD);
   assign capture = ext_event && (t2_mode == T2_CAPTURE);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         prescale_r <= 1'b0;
         t1_half_r <= 1'b0;
         t2_ovf_r <= 1'b0;
      end else begin
         prescale_r <= ~prescale_r;
         t1_half_r <= timer1_overflow ? ~t1_half_r : t1_half_r;
         t2_ovf_r <= ovf;
      end
   end

   // A software write to a count byte wins over counting in the same cycle.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         count_r <= TIMER2_COUNT_RESET;
      end else begin
         if (reload) begin
            count_r <= rcap_r;
         end else if (count_event) begin
            count_r <= count_r + 16'h0001;
         end
         if (wr_hit(sfr_req, TIMER2_COUNT_LOW_ADDR)) begin
            count_r[7:0] <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, TIMER2_COUNT_HIGH_ADDR)) begin
            count_r[15:8] <= sfr_req.wdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rcap_r <= RELOAD_CAPTURE_RESET;
      end else begin
         if (capture) begin
            rcap_r <= count_r;
         end
         if (wr_hit(sfr_req, RELOAD_CAPTURE_LOW_ADDR)) begin
            rcap_r[7:0] <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, RELOAD_CAPTURE_HIGH_ADDR)) begin
            rcap_r[15:8] <= sfr_req.wdata;
         end
      end
   end

   // Flags: a hardware set in the same cycle as a software clear is kept.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         timer2_control_r <= timer2_control_t'(TIMER2_CONTROL_RESET);
      end else begin
         if (wr_hit(sfr_req, TIMER2_CONTROL_ADDR)) begin
            timer2_control_r <= timer2_control_t'(sfr_req.wdata);
         end
         if (ovf && t2_mode != T2_BAUD) begin
            timer2_control_r.timer2_overflow_flag <= 1'b1;
         end
         if (ext_event) begin
            timer2_control_r.ext_trigger_flag <= 1'b1;
         end
      end
   end

   // Serial bit clocks: sixteen oversample ticks per bit.
   logic fixed_tick;
   logic t1_tick;
   logic tx_tick;
   logic rx_tick;
   logic uart9;
   assign fixed_tick = baud_double | prescale_r;
   assign t1_tick = timer1_overflow & (baud_double | t1_half_r);
   assign uart9 = serial_control_r.mode_select[1];
   assign tx_tick = (serial_control_r.mode_select == SER_UART9_FIXED) ? fixed_tick
      : (timer2_control_r.tx_clock_select ? t2_ovf_r : t1_tick);
   assign rx_tick = (serial_control_r.mode_select == SER_UART9_FIXED) ? fixed_tick
      : (timer2_control_r.rx_clock_select ? t2_ovf_r : t1_tick);

   // Transmit engine.
   tx_state_t tx_state_r;
   logic [9:0] tx_shift_r;
   logic [3:0] tx_bit_r;
   logic [3:0] tx_phase_r;
   logic tx_line_r;
   logic tx_clk_r;
   logic tx_data_out_r;
   logic ti_set;
   logic [3:0] tx_stop;
   assign tx_stop = uart9 ? UART9_STOP_INDEX : UART8_STOP_INDEX;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 10'h3FF;
         tx_bit_r <= 4'h0;
         tx_phase_r <= 4'h0;
         tx_line_r <= 1'b1;
         tx_clk_r <= 1'b1;
         tx_data_out_r <= 1'b1;
         ti_set <= 1'b0;
      end else begin
         ti_set <= 1'b0;
         if (wr_hit(sfr_req, SERIAL_DATA_BUFFER_ADDR)) begin
            // stop bit fills the ninth slot in 8-bit mode.
            tx_shift_r <= {1'b1, uart9 ? serial_control_r.tx_ninth_bit : 1'b1, sfr_req.wdata};
            tx_bit_r <= 4'h0;
            tx_phase_r <= 4'h0;
            if (serial_control_r.mode_select == SER_SHIFT) begin
               tx_state_r <= TX_SHIFT;
            end else begin
               tx_state_r <= TX_UART;
               tx_line_r <= 1'b0;
            end
         end else begin
            case (tx_state_r)
               TX_UART: begin
                  if (tx_tick) begin
                     tx_phase_r <= tx_phase_r + 4'h1;
                     if (tx_phase_r == OVERSAMPLE_LAST) begin
                        if (tx_bit_r == tx_stop) begin
                           tx_state_r <= TX_IDLE;
                           tx_line_r <= 1'b1;
                        end else begin
                           tx_bit_r <= tx_bit_r + 4'h1;
                           tx_line_r <= tx_shift_r[0];
                           tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                           ti_set <= (tx_bit_r + 4'h1) == tx_stop;
                        end
                     end
                  end
               end
               TX_SHIFT: begin
                  // Each clock is half a bit, so one bit takes two clocks.
                  begin
                     tx_phase_r[0] <= ~tx_phase_r[0];
                     if (!tx_phase_r[0]) begin
                        tx_clk_r <= 1'b0;
                        tx_data_out_r <= tx_shift_r[0];
                     end else begin
                        tx_clk_r <= 1'b1;
                        tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                        if (tx_bit_r == SHIFT_LAST_BIT) begin
                           tx_state_r <= TX_IDLE;
                           ti_set <= 1'b1;
                        end
                     end
                  end
               end
               default: begin
                  tx_clk_r <= 1'b1;
                  tx_data_out_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // Receive engine; the shift register is separate from the read buffer.
   rx_state_t rx_state_r;
   logic [8:0] rx_shift_r;
   logic [3:0] rx_bit_r;
   logic [3:0] rx_phase_r;
   logic rx_clk_r;
   logic ri_set;
   logic rb8_load;
   logic rb8_val;
   logic [3:0] rx_last;
   logic rx_accept;
   assign rx_last = uart9 ? UART9_LAST_DATA : UART8_LAST_DATA;
   assign rx_accept = !serial_control_r.multiproc_filter
      || (uart9 ? rx_shift_r[8] : rxd_s);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_state_r <= RX_IDLE;
         rx_shift_r <= 9'h000;
         rx_bit_r <= 4'h0;
         rx_phase_r <= 4'h0;
         rx_clk_r <= 1'b1;
         rx_buf_r <= SERIAL_DATA_BUFFER_RESET;
         ri_set <= 1'b0;
         rb8_load <= 1'b0;
         rb8_val <= 1'b0;
      end else begin
         ri_set <= 1'b0;
         rb8_load <= 1'b0;
         if (!serial_control_r.rx_enable) begin
            rx_state_r <= RX_IDLE;
            rx_clk_r <= 1'b1;
         end else begin
            case (rx_state_r)
               RX_IDLE: begin
                  rx_bit_r <= 4'h0;
                  rx_phase_r <= 4'h0;
                  rx_clk_r <= 1'b1;
                  if (serial_control_r.mode_select == SER_SHIFT) begin
                     if (!serial_control_r.rx_done_flag && tx_state_r == TX_IDLE) begin
                        rx_state_r <= RX_SHIFT;
                     end
                  end else if (rxd_fall) begin
                     rx_state_r <= RX_UART;
                  end
               end
               RX_UART: begin
                  if (rx_tick) begin
                     rx_phase_r <= rx_phase_r + 4'h1;
                     if (rx_phase_r == SAMPLE_PHASE) begin
                        if (rx_bit_r == 4'h0) begin
                           // A start bit that reads high mid-bit was a glitch.
                           rx_state_r <= rxd_s ? RX_IDLE : RX_UART;
                           rx_bit_r <= 4'h1;
                        end else if (rx_bit_r <= rx_last) begin
                           rx_shift_r <= {rxd_s, rx_shift_r[8:1]};
                           rx_bit_r <= rx_bit_r + 4'h1;
                        end else begin
                           rx_state_r <= RX_IDLE;
                           if (rx_accept) begin
                              // an unread byte is overwritten here.
                              rx_buf_r <= uart9 ? rx_shift_r[7:0] : rx_shift_r[8:1];
                              rb8_load <= 1'b1;
                              rb8_val <= uart9 ? rx_shift_r[8] : rxd_s;
                              ri_set <= 1'b1;
                           end
                        end
                     end
                  end
               end
               RX_SHIFT: begin
                  begin
                     rx_phase_r[0] <= ~rx_phase_r[0];
                     if (!rx_phase_r[0]) begin
                        rx_clk_r <= 1'b0;
                     end else begin
                        rx_clk_r <= 1'b1;
                        rx_shift_r <= {rxd_s, rx_shift_r[8:1]};
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == SHIFT_LAST_BIT) begin
                           rx_state_r <= RX_IDLE;
                           rx_buf_r <= {rxd_s, rx_shift_r[8:2]};
                           ri_set <= 1'b1;
                        end
                     end
                  end
               end
               default: begin
                  rx_state_r <= RX_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         serial_control_r <= serial_control_t'(SERIAL_CONTROL_RESET);
      end else begin
         if (wr_hit(sfr_req, SERIAL_CONTROL_ADDR)) begin
            serial_control_r <= serial_control_t'(sfr_req.wdata);
         end
         if (rb8_load) begin
            serial_control_r.rx_ninth_bit <= rb8_val;
         end
         if (ti_set) begin
            serial_control_r.tx_done_flag <= 1'b1;
         end
         if (ri_set) begin
            serial_control_r.rx_done_flag <= 1'b1;
         end
      end
   end

   // Pin drivers: in shift mode the transmit pin carries the shift clock.
   logic txd_r;
   logic rxd_out_r;
   logic rxd_oe_r;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         txd_r <= 1'b1;
         rxd_out_r <= 1'b1;
         rxd_oe_r <= 1'b0;
      end else begin
         if (tx_state_r == TX_SHIFT) begin
            txd_r <= tx_clk_r;
         end else if (rx_state_r == RX_SHIFT) begin
            txd_r <= rx_clk_r;
         end else begin
            txd_r <= tx_line_r;
         end
         rxd_out_r <= tx_data_out_r;
         rxd_oe_r <= tx_state_r == TX_SHIFT;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_r <= UNMAPPED_READ;
      end else if (sfr_req.rd) begin
         if (sfr_req.addr == SERIAL_CONTROL_ADDR) begin
            rdata_r <= serial_control_r;
         end else if (sfr_req.addr == SERIAL_DATA_BUFFER_ADDR) begin
            rdata_r <= rx_buf_r;
         end else if (sfr_req.addr == TIMER2_CONTROL_ADDR) begin
            rdata_r <= timer2_control_r;
         end else if (sfr_req.addr == RELOAD_CAPTURE_LOW_ADDR) begin
            rdata_r <= rcap_r[7:0];
         end else if (sfr_req.addr == RELOAD_CAPTURE_HIGH_ADDR) begin
            rdata_r <= rcap_r[15:8];
         end else if (sfr_req.addr == TIMER2_COUNT_LOW_ADDR) begin
            rdata_r <= count_r[7:0];
         end else if (sfr_req.addr == TIMER2_COUNT_HIGH_ADDR) begin
            rdata_r <= count_r[15:8];
         end else begin
            rdata_r <= UNMAPPED_READ;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         timer2_irq_r <= 1'b0;
         serial_irq_r <= 1'b0;
      end else begin
         timer2_irq_r <= timer2_control_r.timer2_overflow_flag | timer2_control_r.ext_trigger_flag;
         serial_irq_r <= serial_control_r.tx_done_flag | serial_control_r.rx_done_flag;
      end
   end

   assign sfr_rdata = rdata_r;
   assign txd = txd_r;
   assign rxd_out = rxd_out_r;
   assign rxd_oe = rxd_oe_r;
   assign timer2_irq = timer2_irq_r;
   assign serial_irq = serial_irq_r;
   assign timer2_overflow_pulse = t2_ovf_r;

endmodule

// ### sim/timer2_uart_assertions.sv
// Port-level checker for the timer 2 and serial port block.
module timer2_uart_assertions
   import timer2_uart_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic baud_double,
   input wire logic timer1_overflow,
   input wire logic ext_trigger_pin,
   input wire logic timer2_count_input,
   input wire logic rxd_in,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   input wire logic txd,
   input wire logic timer2_irq,
   input wire logic serial_irq,
   input wire logic timer2_overflow_pulse
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   ser_mode_t mode_r;
   logic run_r;
   // Software alone writes the mode and run bits, so mirroring the writes tracks them exactly.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mode_r <= SER_SHIFT;
      end else if (sfr_req.wr && sfr_req.addr == SERIAL_CONTROL_ADDR) begin
         mode_r <= ser_mode_t'(sfr_req.wdata[7:6]);
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         run_r <= 1'b0;
      end else if (sfr_req.wr && sfr_req.addr == TIMER2_CONTROL_ADDR) begin
         run_r <= sfr_req.wdata[2];
      end
   end
   reset_values_a: assert property (
      $fell(srst) |-> txd && !rxd_oe && !timer2_irq && !serial_irq && !timer2_overflow_pulse)
      else $error("outputs not at reset values");
   read_hold_a: assert property (
      !sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   unmapped_read_a: assert property (
      sfr_req.rd && !(sfr_req.addr inside {8'h98, 8'h99, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd})
      |=> sfr_rdata == UNMAPPED_READ)
      else $error("unmapped read not zero");
   serial_irq_a: assert property (
      sfr_req.rd && sfr_req.addr == SERIAL_CONTROL_ADDR |=> serial_irq == |sfr_rdata[1:0])
      else $error("serial interrupt disagrees with done flags");
   timer_irq_a: assert property (
      sfr_req.rd && sfr_req.addr == TIMER2_CONTROL_ADDR |=> timer2_irq == |sfr_rdata[7:6])
      else $error("timer interrupt disagrees with flags");
   uart_start_a: assert property (
      sfr_req.wr && sfr_req.addr == SERIAL_DATA_BUFFER_ADDR && mode_r != SER_SHIFT |-> ##2 !txd)
      else $error("start bit missing after buffer write");
   shift_drive_a: assert property (
      rxd_oe |-> mode_r == SER_SHIFT)
      else $error("receive pin driven outside shift mode");
   pulse_run_a: assert property (
      timer2_overflow_pulse |-> $past(run_r))
      else $error("overflow while timer stopped");
endmodule
bind timer2_uart timer2_uart_assertions checker_i (.core_clk(core_clk), .srst(srst),
   .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .baud_double(baud_double),
   .timer1_overflow(timer1_overflow), .ext_trigger_pin(ext_trigger_pin),
   .timer2_count_input(timer2_count_input), .rxd_in(rxd_in), .rxd_out(rxd_out),
   .rxd_oe(rxd_oe), .txd(txd), .timer2_irq(timer2_irq), .serial_irq(serial_irq),
   .timer2_overflow_pulse(timer2_overflow_pulse));

// ### sim/serial_node.sv
// Remote serial node: sends 9-bit UART frames and decodes frames seen on txd.
module serial_node #(
   parameter int BIT_CLKS = 16
)
(
   input wire logic core_clk,
   input wire logic txd,
   output logic line_out,
   output logic [8:0] got_r
);
   timeunit 1ns;
   timeprecision 100ps;
   initial line_out = 1'b1;
   task automatic send(input logic [7:0] data, input logic ninth);
      logic [10:0] frame;
      frame = {1'b1, ninth, data, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_out <= frame[i];
         repeat (BIT_CLKS) @(posedge core_clk);
      end
   endtask
   // Samples each bit at its middle, LSB first, then waits to the middle of the stop bit.
   always begin
      @(negedge txd);
      repeat (BIT_CLKS / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CLKS) @(posedge core_clk);
         got_r[i] = txd;
      end
      repeat (BIT_CLKS) @(posedge core_clk);
   end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the timer 2 and serial port block.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import timer2_uart_pkg::*;
   localparam int LIMIT = 20000;
   logic core_clk, srst, baud_double, ext_trigger_pin, timer2_count_input;
   logic rxd_out, rxd_oe, txd, node_line, timer2_irq, serial_irq, ovf_pulse;
   logic t1_ovf, txd_q;
   logic [7:0] shift_got;
   int pulses = 0;
   logic [7:0] sfr_rdata;
   logic [8:0] got;
   sfr_req_t sfr_req;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   timer2_uart dut (.core_clk(core_clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .baud_double(baud_double), .timer1_overflow(t1_ovf), .ext_trigger_pin(ext_trigger_pin),
      .timer2_count_input(timer2_count_input), .rxd_in(rxd_oe ? rxd_out : node_line),
      .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .timer2_irq(timer2_irq),
      .serial_irq(serial_irq), .timer2_overflow_pulse(ovf_pulse));
   serial_node node (.core_clk(core_clk), .txd(txd), .line_out(node_line), .got_r(got));
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // The bus is idled for a cycle after every access so no strobe is driven twice in a step.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      sfr_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      sfr_req <= '0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(sfr_rdata, e);
   endtask
   task automatic fall(input logic ext);
      ext_trigger_pin <= !ext;
      timer2_count_input <= ext;
      repeat (6) @(posedge core_clk);
      ext_trigger_pin <= 1'b1;
      timer2_count_input <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         $display("BAD at %0t: run timed out", $time);
         conclude();
      end
   end
   // Shift data is taken one cycle after each rising shift clock, where it still stands.
   always @(posedge core_clk) begin
      txd_q <= txd;
      if (txd && !txd_q) begin
         shift_got <= {rxd_out, shift_got[7:1]};
      end
      if (ovf_pulse === 1'b1) begin
         pulses++;
      end
   end
   initial begin
      srst = 1'b1;
      sfr_req = '0;
      baud_double = 1'b1;
      t1_ovf = 1'b0;
      ext_trigger_pin = 1'b1;
      timer2_count_input = 1'b1;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rdchk(SERIAL_CONTROL_ADDR, SERIAL_CONTROL_RESET);
      rdchk(TIMER2_CONTROL_ADDR, TIMER2_CONTROL_RESET);
      rdchk(TIMER2_COUNT_LOW_ADDR, 8'h00);
      rdchk(RELOAD_CAPTURE_HIGH_ADDR, 8'h00);
      wr(8'h42, 8'hff);
      rdchk(8'h42, UNMAPPED_READ);
      $display("test reset done");
      wr(RELOAD_CAPTURE_LOW_ADDR, 8'hf0);
      wr(RELOAD_CAPTURE_HIGH_ADDR, 8'hff);
      wr(TIMER2_COUNT_HIGH_ADDR, 8'hff);
      wr(TIMER2_COUNT_LOW_ADDR, 8'hfe);
      wr(TIMER2_CONTROL_ADDR, 8'h04);
      repeat (40) @(posedge core_clk);
      rdchk(TIMER2_COUNT_HIGH_ADDR, 8'hff);
      rdchk(TIMER2_CONTROL_ADDR, 8'h84);
      wr(TIMER2_CONTROL_ADDR, 8'h0e);
      wr(TIMER2_COUNT_HIGH_ADDR, 8'h12);
      wr(TIMER2_COUNT_LOW_ADDR, 8'h34);
      fall(1'b1);
      rdchk(TIMER2_COUNT_LOW_ADDR, 8'hf0);
      rdchk(TIMER2_CONTROL_ADDR, 8'h4e);
      $display("test autoreload done");
      wr(TIMER2_CONTROL_ADDR, 8'h0f);
      wr(TIMER2_COUNT_HIGH_ADDR, 8'h12);
      wr(TIMER2_COUNT_LOW_ADDR, 8'h34);
      fall(1'b1);
      rdchk(RELOAD_CAPTURE_LOW_ADDR, 8'h34);
      rdchk(RELOAD_CAPTURE_HIGH_ADDR, 8'h12);
      rdchk(TIMER2_CONTROL_ADDR, 8'h4f);
      repeat (3) fall(1'b0);
      rdchk(TIMER2_COUNT_LOW_ADDR, 8'h37);
      wr(TIMER2_COUNT_HIGH_ADDR, 8'hff);
      wr(TIMER2_COUNT_LOW_ADDR, 8'hff);
      fall(1'b0);
      rdchk(TIMER2_COUNT_HIGH_ADDR, 8'h00);
      rdchk(TIMER2_CONTROL_ADDR, 8'hcf);
      $display("test capture done");
      wr(TIMER2_COUNT_HIGH_ADDR, 8'hff);
      wr(TIMER2_COUNT_LOW_ADDR, 8'hf0);
      pulses = 0;
      wr(TIMER2_CONTROL_ADDR, 8'h3c);
      repeat (64) @(posedge core_clk);
      fall(1'b1);
      rdchk(TIMER2_CONTROL_ADDR, 8'h7c);
      rdchk(TIMER2_COUNT_HIGH_ADDR, 8'h12);
      chk(8'(pulses), 8'h01);
      wr(TIMER2_CONTROL_ADDR, 8'h00);
      $display("test baud done");
      wr(SERIAL_CONTROL_ADDR, 8'h98);
      fork
         wr(SERIAL_DATA_BUFFER_ADDR, 8'ha5);
         node.send(8'h3c, 1'b1);
      join
      repeat (20) @(posedge core_clk);
      chk(got[7:0], 8'ha5);
      chk({7'h00, got[8]}, 8'h01);
      rdchk(SERIAL_DATA_BUFFER_ADDR, 8'h3c);
      rdchk(SERIAL_CONTROL_ADDR, 8'h9f);
      wr(SERIAL_CONTROL_ADDR, 8'hb0);
      node.send(8'h55, 1'b0);
      repeat (8) @(posedge core_clk);
      rdchk(SERIAL_CONTROL_ADDR, 8'hb0);
      node.send(8'h11, 1'b1);
      node.send(8'h22, 1'b1);
      repeat (8) @(posedge core_clk);
      rdchk(SERIAL_DATA_BUFFER_ADDR, 8'h22);
      wr(SERIAL_CONTROL_ADDR, 8'h80);
      node.send(8'h77, 1'b1);
      repeat (8) @(posedge core_clk);
      rdchk(SERIAL_CONTROL_ADDR, 8'h80);
      t1_ovf <= 1'b1;
      wr(SERIAL_CONTROL_ADDR, 8'h70);
      node.send(8'h66, 1'b0);
      repeat (8) @(posedge core_clk);
      rdchk(SERIAL_CONTROL_ADDR, 8'h70);
      node.send(8'h99, 1'b1);
      repeat (8) @(posedge core_clk);
      rdchk(SERIAL_DATA_BUFFER_ADDR, 8'h99);
      rdchk(SERIAL_CONTROL_ADDR, 8'h75);
      $display("test uart done");
      wr(SERIAL_CONTROL_ADDR, 8'h00);
      wr(SERIAL_DATA_BUFFER_ADDR, 8'h5a);
      repeat (60) @(posedge core_clk);
      rdchk(SERIAL_CONTROL_ADDR, 8'h02);
      chk(shift_got, 8'h5a);
      $display("test shift done");
      conclude();
   end
endmodule
